// >>> hw/plri_params.svh
`ifndef PLRI_PARAMS_SVH
`define PLRI_PARAMS_SVH

// Rate of the local reference clock.
`define PLRI_SYS_CLK_MHZ 200
// Inactive time after which the interface is reset, least value in ns.
`define PLRI_RESET_DELAY_NS 2600
`define PLRI_RESET_CYCLES ((`PLRI_RESET_DELAY_NS * `PLRI_SYS_CLK_MHZ + 999) / 1000)
// Inactive time after which the interface is disabled, least value in ns.
`define PLRI_DISABLE_DELAY_NS 26030
`define PLRI_DISABLE_CYCLES ((`PLRI_DISABLE_DELAY_NS * `PLRI_SYS_CLK_MHZ + 999) / 1000)
// Clock restart from the low-power state, least value in us.
`define PLRI_WAKE_LP_US 5300
`define PLRI_WAKE_LP_CYCLES (`PLRI_WAKE_LP_US * `PLRI_SYS_CLK_MHZ)
// Clock restart outside the low-power state, longest value in ns.
`define PLRI_WAKE_FAST_NS 60
`define PLRI_WAKE_FAST_CYCLES ((`PLRI_WAKE_FAST_NS * `PLRI_SYS_CLK_MHZ) / 1000)
// Half period of the link clock in local clock cycles.
`define PLRI_CLK_HALF_CYCLES 2
// Codes on the interface control lines.
`define PLRI_CTL_IDLE 2'h0
`define PLRI_CTL_RECEIVE 2'h2
// Link clock cycles of the initialization sequence.
`define PLRI_INIT_FIRST_CYCLE 4'h1
`define PLRI_INIT_LOW_LAST 4'h7
`define PLRI_INIT_RECEIVE_CYCLE 4'h8

`endif

// >>> hw/plri_pkg.sv
`default_nettype none

package plri_pkg;

    // Interface states.
    typedef enum logic [2:0] {
        PLRI_ST_DISABLED,
        PLRI_ST_WAKE,
        PLRI_ST_RESET,
        PLRI_ST_INIT,
        PLRI_ST_NORMAL
    } plri_state_e;

    typedef logic [1:0] plri_ctl_t;
    typedef logic [3:0] plri_cycle_t;

endpackage : plri_pkg

`default_nettype wire

// >>> hw/plri_clk_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the link clock control between the sequencer and the clock divider.
interface plri_clk_if;
    logic run;
    logic iso_nondiff;
    logic clk_level;
    logic clk_oe_n;
    logic cycle_pulse;

    modport gen (input run, input iso_nondiff, output clk_level, output clk_oe_n, output cycle_pulse);
    modport ctrl (output run, output iso_nondiff, input clk_level, input clk_oe_n, input cycle_pulse);
endinterface : plri_clk_if

`default_nettype wire

// >>> hw/plri_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
`include "plri_params.svh"

// Divides the local clock down to the link clock and marks each rising edge.
module plri_clkgen #(
    parameter int HALF_CYCLES = `PLRI_CLK_HALF_CYCLES
) (
    // Clock and synchronised reset.
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    // Clock control.
    plri_clk_if.gen cif
);
    import plri_pkg::*;

    localparam int CW = $clog2(HALF_CYCLES + 1);

    logic [CW-1:0] phase_reg;
    logic level_reg;
    logic pulse_reg;
    logic oe_n_reg;
    wire logic phase_end;

    assign phase_end = (phase_reg == CW'(HALF_CYCLES - 1));

    // A fresh start always spends half a period low before the first rise.
    // Counting waits until the pin is driven, so a floated clock still gets a whole low half.
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            phase_reg <= '0;
            level_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else if (!cif.run || oe_n_reg)
        begin
            phase_reg <= '0;
            level_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_end ? '0 : phase_reg + 1'b1;
            level_reg <= phase_end ? !level_reg : level_reg;
            pulse_reg <= phase_end && !level_reg;
        end
    end

    // A stopped clock floats in differentiated mode and is held low otherwise.
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            oe_n_reg <= 1'b1;
        else
            oe_n_reg <= !(cif.run || cif.iso_nondiff);
    end

    assign cif.clk_level = level_reg;
    assign cif.clk_oe_n = oe_n_reg;
    assign cif.cycle_pulse = pulse_reg;

endmodule : plri_clkgen

`default_nettype wire

// >>> hw/plri_top.sv
// What this block does
// - Differentiated mode: after reset delay, outputs end low, float, interface reset.
// - Nondifferentiated mode: after reset delay, outputs driven low, interface reset.
// - Differentiated mode: after disable delay the link clock floats; interface disabled.
// - Nondifferentiated mode: after disable delay the link clock is held low; disabled.
// - Reassertion from reset or from disabled always runs initialization.
// - Clock restarts 5.3 to 7.3 ms from low power, otherwise within 60 ns.
// - Restarted link clock is a 50 percent duty square wave.
// - Differentiated mode: clock starts with half a period low.
// - Differentiated mode: first full cycle drives control and data low once.
// - Nondifferentiated mode: control and data held low for first seven cycles.
// - Eighth cycle shows receive code and all-ones data, driven in both modes.
// - Idle code and zero data end initialization; requests accepted only then.
// - Inactivity of 2.60 to 2.68 us resets the interface.
// - Inactivity of 26.03 to 26.11 us disables the interface.
// - Outside normal operation requests are cancelled and ignored.
`timescale 1ns/1ps
`default_nettype none
`include "plri_params.svh"

module plri_top #(
    parameter int DATA_W = 8,
    parameter int DISABLE_CYCLES = `PLRI_DISABLE_CYCLES,
    parameter int WAKE_LP_CYCLES = `PLRI_WAKE_LP_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins from the link controller.
    input wire logic link_power_status,
    input wire logic link_request_line,
    input wire logic iso_mode,
    // Power state of the cable ports.
    input wire logic ports_active,
    // Link clock pin.
    output logic link_clock_output,
    output logic link_clock_oe_n,
    // Control and data lines.
    output plri_pkg::plri_ctl_t interface_control_lines,
    output logic interface_control_oe_n,
    output logic [DATA_W-1:0] interface_data_lines,
    output logic interface_data_oe_n,
    // Towards the rest of the device.
    output logic request_sampled,
    output logic requests_cancel,
    output logic interface_operational
);
    import plri_pkg::*;

    localparam int ICW = 24;
    localparam int WCW = 24;

    plri_clk_if cif ();

    logic rst_meta_reg;
    logic rst_sync_reg;
    wire logic rst_sync_n;

    // Reset asserts at once and releases through two flip-flops.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_sync_n = rst_sync_reg;

    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    wire logic lps_s;
    wire logic link_request_line_s;
    wire logic iso_s;

    // Two-stage synchronisers for the pins.
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end
        else
        begin
            pin_meta_reg <= {iso_mode, link_request_line, link_power_status};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign lps_s = pin_sync_reg[0];
    assign link_request_line_s = pin_sync_reg[1];
    assign iso_s = pin_sync_reg[2];

    logic [ICW-1:0] idle_cnt_reg;
    wire logic reset_hit;
    wire logic disable_hit;

    // Inactivity timer; a pulsed status line clears it on every high phase.
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            idle_cnt_reg <= '0;
        else if (lps_s)
            idle_cnt_reg <= '0;
        else if (!disable_hit)
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
    assign reset_hit = (idle_cnt_reg == ICW'(`PLRI_RESET_CYCLES));
    assign disable_hit = (idle_cnt_reg == ICW'(DISABLE_CYCLES));

    plri_state_e state_reg;
    plri_state_e state_next;
    plri_cycle_t cyc_reg;
    plri_cycle_t cyc_next;
    logic [WCW-1:0] wake_cnt_reg;
    logic [WCW-1:0] wake_cnt_next;
    wire logic [WCW-1:0] wake_load;

    // A disabled interface with no active port sleeps and wakes slowly.
    assign wake_load = ports_active ? WCW'(`PLRI_WAKE_FAST_CYCLES - 1) : WCW'(WAKE_LP_CYCLES - 1);

    // Interface state sequencing.
    always_comb
    begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        wake_cnt_next = wake_cnt_reg;
        unique case (state_reg)
            PLRI_ST_DISABLED:
            begin
                if (lps_s)
                begin
                    state_next = PLRI_ST_WAKE;
                    wake_cnt_next = wake_load;
                end
            end
            PLRI_ST_WAKE:
            begin
                if (disable_hit)
                    state_next = PLRI_ST_DISABLED;
                else if (wake_cnt_reg == '0)
                begin
                    state_next = PLRI_ST_INIT;
                    cyc_next = '0;
                end
                else
                    wake_cnt_next = wake_cnt_reg - 1'b1;
            end
            PLRI_ST_RESET:
            begin
                if (lps_s)
                begin
                    state_next = PLRI_ST_INIT;
                    cyc_next = '0;
                end
                else if (disable_hit)
                    state_next = PLRI_ST_DISABLED;
            end
            PLRI_ST_INIT:
            begin
                if (disable_hit)
                    state_next = PLRI_ST_DISABLED;
                else if (reset_hit)
                    state_next = PLRI_ST_RESET;
                else if (cif.cycle_pulse)
                begin
                    if (cyc_reg == `PLRI_INIT_RECEIVE_CYCLE)
                        state_next = PLRI_ST_NORMAL;
                    else
                        cyc_next = cyc_reg + 1'b1;
                end
            end
            PLRI_ST_NORMAL:
            begin
                if (reset_hit)
                    state_next = PLRI_ST_RESET;
            end
        endcase
    end

    // State registers; a hardware reset leaves the interface disabled.
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_reg <= PLRI_ST_DISABLED;
            cyc_reg <= '0;
            wake_cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // The clock runs in every state but disabled and waking.
    assign cif.run = (state_reg != PLRI_ST_DISABLED) && (state_reg != PLRI_ST_WAKE);
    assign cif.iso_nondiff = iso_s;

    plri_clkgen #(
        .HALF_CYCLES(`PLRI_CLK_HALF_CYCLES)
    ) u_clkgen (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .cif(cif)
    );

    wire logic in_init;
    wire logic init_low_zone;
    wire logic init_receive;
    wire logic drive_next;
    wire plri_ctl_t ctl_next;
    wire logic data_ones_next;

    // Line values per state: parked low, low-drive phase, receive, then idle.
    assign in_init = (state_reg == PLRI_ST_INIT);
    assign init_low_zone = in_init && (cyc_reg >= `PLRI_INIT_FIRST_CYCLE) && (cyc_reg <= `PLRI_INIT_LOW_LAST);
    assign init_receive = in_init && (cyc_reg == `PLRI_INIT_RECEIVE_CYCLE);
    assign ctl_next = init_receive ? `PLRI_CTL_RECEIVE : `PLRI_CTL_IDLE;
    assign data_ones_next = init_receive;
    // Differentiated lines float when parked and after the first low cycle.
    assign drive_next = (state_reg == PLRI_ST_NORMAL) || init_receive
        || (init_low_zone && (iso_s || cyc_reg == `PLRI_INIT_FIRST_CYCLE))
        || (iso_s && !init_low_zone);

    logic operational_reg;
    logic cancel_reg;
    logic req_reg;

    // Registered line outputs and request gating.
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            interface_control_lines <= `PLRI_CTL_IDLE;
            interface_data_lines <= '0;
            interface_control_oe_n <= 1'b1;
            interface_data_oe_n <= 1'b1;
            operational_reg <= 1'b0;
            cancel_reg <= 1'b0;
            req_reg <= 1'b0;
        end
        else
        begin
            interface_control_lines <= ctl_next;
            interface_data_lines <= data_ones_next ? '1 : '0;
            interface_control_oe_n <= !drive_next;
            interface_data_oe_n <= !drive_next;
            operational_reg <= (state_reg == PLRI_ST_NORMAL);
            cancel_reg <= operational_reg && (state_reg != PLRI_ST_NORMAL);
            req_reg <= link_request_line_s && (state_reg == PLRI_ST_NORMAL);
        end
    end

    assign link_clock_output = cif.clk_level;
    assign link_clock_oe_n = cif.clk_oe_n;
    assign request_sampled = req_reg;
    assign requests_cancel = cancel_reg;
    assign interface_operational = operational_reg;

endmodule : plri_top

`default_nettype wire

// >>> testbench/plri_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the pins of the sequencer against the time the status pin has stayed low.
module plri_monitor #(
    parameter int DATA_W = 8,
    parameter int DISABLE_CYCLES = 5206
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Inputs of the block.
    input wire logic link_power_status,
    input wire logic iso_mode,
    input wire logic ports_active,
    // Outputs of the block.
    input wire logic link_clock_output,
    input wire logic link_clock_oe_n,
    input wire plri_pkg::plri_ctl_t interface_control_lines,
    input wire logic interface_control_oe_n,
    input wire logic [DATA_W-1:0] interface_data_lines,
    input wire logic interface_data_oe_n,
    input wire logic request_sampled,
    input wire logic requests_cancel,
    input wire logic interface_operational
);
    import plri_pkg::*;
    logic [12:0] lo_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Counts the cycles the status pin has been low, saturating at the top.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            lo_reg <= 13'h0000;
        else
            lo_reg <= link_power_status ? 13'h0000 : lo_reg + 13'(lo_reg != 13'h1FFF);
    end

    chk_reset_early: assert property ($fell(interface_operational) |-> lo_reg >= 13'h0208)
        else $error("interface left normal state too early");
    chk_reset_late: assert property (lo_reg == 13'h0218 |-> !interface_operational)
        else $error("interface not reset in time");
    chk_reset_lines: assert property (lo_reg == 13'h0218 |-> interface_control_lines == 2'h0
        && interface_data_lines == '0 && interface_control_oe_n == !iso_mode && interface_data_oe_n == !iso_mode)
        else $error("lines not parked in reset");
    chk_disable_clk: assert property (lo_reg == DISABLE_CYCLES + 16 |-> link_clock_oe_n == !iso_mode
        && (!iso_mode || !link_clock_output))
        else $error("link clock not stopped in time");
    chk_duty_high: assert property ($rose(link_clock_output) && lo_reg == 13'h0000
        |=> link_clock_output ##1 !link_clock_output)
        else $error("link clock high half wrong");
    chk_start_low: assert property ($fell(link_clock_oe_n) && !iso_mode |-> !link_clock_output [*2])
        else $error("link clock did not start low");
    chk_wake_fast: assert property ($rose(link_power_status) && ports_active && lo_reg > DISABLE_CYCLES + 16
        |-> ##[1:30] $rose(link_clock_output))
        else $error("link clock restart too slow");
    chk_req_gate: assert property (!interface_operational |-> !request_sampled)
        else $error("request passed outside normal state");
    chk_cancel_out: assert property ($fell(interface_operational) |-> requests_cancel)
        else $error("no cancel on leaving normal state");
    chk_receive_ind: assert property ($rose(interface_operational) |-> $past(interface_control_lines, 2) == 2'h2
        && $past(interface_data_lines, 2) == '1)
        else $error("receive indication missing");
    chk_idle_done: assert property ($rose(interface_operational) |-> interface_control_lines == 2'h0
        && interface_data_lines == '0 && !interface_control_oe_n && !interface_data_oe_n)
        else $error("idle not shown at end of initialization");
endmodule : plri_monitor

bind plri_top plri_monitor #(.DATA_W(DATA_W), .DISABLE_CYCLES(DISABLE_CYCLES)) u_mon (.sys_clk, .rst_n,
    .link_power_status, .iso_mode, .ports_active, .link_clock_output, .link_clock_oe_n, .interface_control_lines,
    .interface_control_oe_n, .interface_data_lines, .interface_data_oe_n, .request_sampled, .requests_cancel,
    .interface_operational);

`default_nettype wire

// >>> testbench/plri_llc_model.sv
`timescale 1ns/1ps
`default_nettype none

// Link controller side: drives status level or pulsed and the request pin.
module plri_llc_model #(
    parameter int RESTORE_CYCLES = 3000
) (
    // Clock.
    input wire logic sys_clk,
    // Commands from the bench.
    input wire logic lps_cmd,
    input wire logic pulsed,
    input wire logic req_cmd,
    // Pins towards the block.
    output logic link_power_status = 1'b0,
    output logic link_request_line = 1'b0
);
    int low_reg = 0;
    int ph_reg = 0;
    logic act_reg = 1'b0;

    // Status rises only after the restore wait; pulses are high 30 of 100 cycles.
    always_ff @(posedge sys_clk)
    begin
        low_reg <= act_reg ? 0 : low_reg + 1;
        act_reg <= lps_cmd && (act_reg || low_reg >= RESTORE_CYCLES);
        ph_reg <= (ph_reg == 99) ? 0 : ph_reg + 1;
        link_power_status <= act_reg && (!pulsed || ph_reg < 30);
        link_request_line <= act_reg && req_cmd;
    end
endmodule : plri_llc_model

`default_nettype wire

// >>> testbench/plri_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Walks the sequencer through initialization, pulsed status, reset and disable.
module plri_top_tb;
    import plri_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic lps_cmd = 1'b0;
    logic pulsed = 1'b0;
    logic req_cmd = 1'b0;
    logic iso_mode = 1'b0;
    logic ports_active = 1'b1;
    logic link_power_status, link_request_line, link_clock_output, link_clock_oe_n;
    logic interface_control_oe_n, interface_data_oe_n, request_sampled, requests_cancel, interface_operational;
    plri_ctl_t interface_control_lines;
    logic [7:0] interface_data_lines;
    int miscompares = 0;
    int n_compared = 0;

    // Local clock of 200 MHz.
    always #2.5 sys_clk = ~sys_clk;

    plri_llc_model u_llc (.sys_clk, .lps_cmd, .pulsed, .req_cmd, .link_power_status, .link_request_line);
    plri_top #(.WAKE_LP_CYCLES(50)) dut (.sys_clk, .rst_n, .link_power_status, .link_request_line, .iso_mode,
        .ports_active, .link_clock_output, .link_clock_oe_n, .interface_control_lines, .interface_control_oe_n,
        .interface_data_lines, .interface_data_oe_n, .request_sampled, .requests_cancel, .interface_operational);

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Waits for the link clock to reach a level; a stuck clock counts a mismatch and ends the run.
    task automatic wait_clk(input logic lvl, output int n);
        for (n = 0; n < 400 && link_clock_output !== lvl; n++) cyc(1);
        if (n == 400)
        begin
            miscompares++;
            $display("[ERR] link clock expected %h seen %h", lvl, link_clock_output);
            results;
        end
    endtask : wait_clk

    task automatic results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic t_up;
        int i;
        logic rx;
        rx = 1'b0;
        lps_cmd = 1'b1;
        for (i = 0; i < 8000 && interface_operational !== 1'b1; i++)
        begin
            if (interface_control_lines === 2'h2 && interface_data_lines === 8'hFF)
                rx = 1'b1;
            cyc(1);
        end
        chk("operational", 8'h01, interface_operational);
        chk("receive seen", 8'h01, rx);
        chk("idle code", 8'h00, interface_control_lines);
        chk("idle data", 8'h00, interface_data_lines);
        chk("lines driven", 8'h00, {interface_control_oe_n, interface_data_oe_n});
        if (i == 8000)
            results;
        $display("t_up done");
    endtask : t_up

    task automatic t_req;
        int i;
        req_cmd = 1'b1;
        cyc(6);
        chk("request passed", 8'h01, request_sampled);
        req_cmd = 1'b0;
        wait_clk(1'b0, i);
        wait_clk(1'b1, i);
        wait_clk(1'b0, i);
        chk("clock high half", 8'h02, 8'(i));
        $display("t_req done");
    endtask : t_req

    task automatic t_pulse;
        logic dropped;
        dropped = 1'b0;
        pulsed = 1'b1;
        repeat (3000)
        begin
            if (interface_operational !== 1'b1)
                dropped = 1'b1;
            cyc(1);
        end
        pulsed = 1'b0;
        chk("pulsed status kept", 8'h00, dropped);
        $display("t_pulse done");
    endtask : t_pulse

    // Holds status low for n cycles, checks the parked pins, then restarts.
    task automatic t_low(input int n, input logic iso, input logic act);
        int i;
        logic cx;
        cx = 1'b0;
        iso_mode = iso;
        cyc(8);
        lps_cmd = 1'b0;
        for (i = 0; i < n; i++)
        begin
            if (requests_cancel === 1'b1)
                cx = 1'b1;
            cyc(1);
        end
        chk("cancel pulse", 8'h01, cx);
        chk("not operational", 8'h00, interface_operational);
        chk("ctl low", 8'h00, interface_control_lines);
        chk("data low", 8'h00, interface_data_lines);
        chk("lines park", {6'h00, ~iso, ~iso}, {interface_control_oe_n, interface_data_oe_n});
        if (n > 5300 - 1)
        begin
            chk("clock stop", {6'h00, ~iso, 1'b0}, {link_clock_oe_n, link_clock_output & iso});
            ports_active = act;
            lps_cmd = 1'b1;
            wait_clk(1'b1, i);
            chk("wake time", 8'h01, act ? i <= 30 : i >= 50 && i <= 80);
        end
        t_up;
        ports_active = 1'b1;
        $display("t_low done");
    endtask : t_low

    // Reset, then the scenarios in turn.
    initial
    begin
        cyc(16);
        rst_n = 1'b1;
        cyc(4);
        t_up;
        t_req;
        t_pulse;
        t_low(3100, 1'b0, 1'b1);
        t_low(3100, 1'b1, 1'b1);
        t_low(5300, 1'b0, 1'b1);
        t_low(5300, 1'b1, 1'b0);
        results;
    end
endmodule : plri_top_tb

`default_nettype wire
